// [rtl/sfp_consts.svh]
// Offsets, field positions, command codes and counts of the serial flash front end.
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// Array geometry.
`define SFP_ADDR_W 18
`define SFP_WIRE_ADDR_W 24
`define SFP_PAGE_BYTES 256
`define SFP_PAGE_W 8
`define SFP_SECT_LSB 12
`define SFP_SECT_MSB 17
`define SFP_BLK_LSB 16
`define SFP_SECT_COUNT 7'h40

// Status byte field positions.
`define SFP_ST_BUSY 0
`define SFP_ST_WEL 1
`define SFP_ST_BP_LSB 2
`define SFP_ST_BP_MSB 4
`define SFP_ST_SRP 7
`define SFP_STATUS_RST 8'h00

// Instruction codes.
`define SFP_CMD_WREN 8'h06
`define SFP_CMD_WRDI 8'h04
`define SFP_CMD_RDSR 8'h05
`define SFP_CMD_WRSR 8'h01
`define SFP_CMD_READ 8'h03
`define SFP_CMD_PROG 8'h02
`define SFP_CMD_SECT 8'h20
`define SFP_CMD_BLK 8'hD8
`define SFP_CMD_CHIP 8'hC7

// Cycles the status write stays busy.
`define SFP_WRSR_CYCLES 16

`endif

// [rtl/sfp_pkg.sv]
// Types shared by the serial flash front end.
package sfp_pkg;
	typedef enum logic [2:0] {
		SFP_S_CMD,
		SFP_S_ADDR,
		SFP_S_READ,
		SFP_S_STAT_OUT,
		SFP_S_STAT_IN,
		SFP_S_PROG,
		SFP_S_SKIP
	} sfp_ser_state_t;

	typedef enum logic [2:0] {
		SFP_OP_NONE,
		SFP_OP_READ,
		SFP_OP_PROG,
		SFP_OP_SECT,
		SFP_OP_BLK,
		SFP_OP_CHIP,
		SFP_OP_WRSR
	} sfp_op_t;

	typedef enum logic [1:0] {
		SFP_E_IDLE,
		SFP_E_FETCH,
		SFP_E_STORE,
		SFP_E_WAIT
	} sfp_eng_t;
endpackage : sfp_pkg

// [rtl/sfp_pin_sync.sv]
// Two-stage synchroniser for pins that come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sfp_pin_sync #(
	parameter int W = 5
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Pins in and synchronised copies out.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;
endmodule : sfp_pin_sync
`default_nettype wire

// [rtl/sfp_byte_mem.sv]
// Byte memory with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module sfp_byte_mem #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 8
) (
	// Clock.
	input wire logic clk_i,
	// Write port.
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] waddr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	// Read port.
	input wire logic [ADDR_W-1:0] raddr_i,
	output logic [DATA_W-1:0] rdata_o
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Write when asked, read every cycle into the output register.
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule : sfp_byte_mem
`default_nettype wire

// [rtl/sfp_flash_front.sv]
// Serial flash front end: pin sampling, pause, instruction handling and program/erase engine.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
// What this block does
// - Take input bits on each rising serial clock edge.
// - Shift read and status bits out on each falling serial clock edge.
// - Chip select high deselects and floats the serial output.
// - Program, erase or status write keeps running after deselect; standby only afterwards.
// - After reset no instruction until chip select falls; host must give that fall.
// - Pause low while selected floats output and ignores input and clock.
// - Pause release resumes the suspended operation from its held state.
// - Write-protect low with status protect blocks status writes; block bits guard array.
// - Array is 1,024 pages of 256 bytes.
// - Program writes at most 256 bytes and only clears bits to zero.
// - Erase a 16-page sector, a 256-page block, or the whole chip.
// - 64 erasable sectors and 4 erasable 64-kilobyte blocks cover the array.
// - Works in SPI modes 0 and 3; host uses one of them.
// - Pause starts and ends with clock low, else after next falling clock edge.
module sfp_flash_front #(
	parameter int ADDR_W = `SFP_ADDR_W,
	parameter int WRSR_CYCLES = `SFP_WRSR_CYCLES
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Serial link pins.
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_n_o,
	// Pause and write-protect pins.
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	// Power state.
	output logic standby_o
);
	import sfp_pkg::*;

	logic [4:0] pins_s;
	logic sclk_s, cs_n_s, sin_s, hold_n_s, wp_n_s;
	logic sclk_q_reg, cs_n_q_reg;
	logic selected_reg, selected_next;
	logic pause_reg, pause_next;
	sfp_ser_state_t state_reg, state_next;
	sfp_op_t pend_reg, pend_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] rx_shift_reg, rx_shift_next;
	logic [1:0] addr_cnt_reg, addr_cnt_next;
	logic [15:0] addr_in_reg, addr_in_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [7:0] tx_shift_reg, tx_shift_next;
	logic [2:0] tx_cnt_reg, tx_cnt_next;
	logic tx_on_reg, tx_on_next;
	logic oe_n_reg, oe_n_next;
	logic wel_reg, wel_next;
	logic [2:0] bp_reg, bp_next;
	logic srp_reg, srp_next;
	logic [7:0] stat_new_reg, stat_new_next;
	logic [`SFP_PAGE_BYTES-1:0] mask_reg, mask_next;
	sfp_eng_t eng_reg, eng_next;
	sfp_op_t op_reg, op_next;
	logic [ADDR_W-1:0] eng_addr_reg, eng_addr_next;
	logic [ADDR_W-1:0] eng_last_reg, eng_last_next;
	logic [15:0] wait_cnt_reg, wait_cnt_next;
	logic start;
	logic mem_we;
	logic [7:0] mem_wdata, mem_rdata, buf_rdata;
	logic buf_we;
	logic [7:0] status_w;

	// Pins pass two flip-flops before any logic reads them.
	sfp_pin_sync #(.W(5)) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i({sclk_i, cs_n_i, serial_in_i, hold_n_i, wp_n_i}),
		.q_o(pins_s)
	);
	assign sclk_s = pins_s[4];
	assign cs_n_s = pins_s[3];
	assign sin_s = pins_s[2];
	assign hold_n_s = pins_s[1];
	assign wp_n_s = pins_s[0];

	// Edge detection on the synchronised clock and select.
	wire sclk_rise = sclk_s & ~sclk_q_reg;
	wire sclk_fall = ~sclk_s & sclk_q_reg;
	wire cs_fall = ~cs_n_s & cs_n_q_reg;
	wire cs_rise = cs_n_s & ~cs_n_q_reg;
	wire busy = (eng_reg != SFP_E_IDLE);
	// mode independent
	// Only edges seen while selected count, so the idle clock level at select edges does not matter.
	wire live = selected_reg & ~cs_n_s & ~pause_reg;
	wire rx_en = live & sclk_rise;
	wire tx_en = live & sclk_fall;
	wire [7:0] rx_byte = {rx_shift_reg[6:0], sin_s};
	wire [`SFP_WIRE_ADDR_W-1:0] addr_full = {addr_in_reg, rx_byte};

	// select needs fall
	// A falling select edge after reset is needed before anything is taken.
	assign selected_next = cs_fall ? 1'b1 : (cs_n_s ? 1'b0 : selected_reg);

	// pause timing
	// The pause level only moves while the clock is low or on deselect, so it waits for the next falling edge.
	// pause holds state
	assign pause_next = cs_n_s ? 1'b0 : (~sclk_s ? ~hold_n_s : pause_reg);

	// Status byte as it is shifted out.
	always_comb
	begin
		status_w = `SFP_STATUS_RST;
		status_w[`SFP_ST_BUSY] = busy;
		status_w[`SFP_ST_WEL] = wel_reg;
		status_w[`SFP_ST_BP_MSB:`SFP_ST_BP_LSB] = bp_reg;
		status_w[`SFP_ST_SRP] = srp_reg;
	end

	// sector and block index
	// Last sector touched by the pending operation, and the first sector that block protection guards.
	wire [5:0] sect_idx = addr_reg[`SFP_SECT_MSB:`SFP_SECT_LSB];
	wire [1:0] blk_idx = addr_reg[`SFP_SECT_MSB:`SFP_BLK_LSB];
	wire [5:0] end_sect = (pend_reg == SFP_OP_CHIP) ? 6'h3F : ((pend_reg == SFP_OP_BLK) ? {blk_idx, 4'hF} : sect_idx);
	wire [6:0] prot_base = (bp_reg == 3'h0) ? `SFP_SECT_COUNT : ((bp_reg > 3'h4) ? 7'h00 : (`SFP_SECT_COUNT - (7'h02 << bp_reg)));
	wire prot_hit = ({1'b0, end_sect} >= prot_base);
	wire wrsr_locked = srp_reg & ~wp_n_s;
	// launch needs full header
	// A frame cut before its address is complete never launches, so stale address or page data is not replayed.
	wire launch_ok = cs_rise & selected_reg & (bit_cnt_reg == 3'h0) & ~busy & (pend_reg != SFP_OP_NONE)
		& ((state_reg == SFP_S_SKIP) | (state_reg == SFP_S_PROG))
		& (pend_reg != SFP_OP_READ) & ~((pend_reg != SFP_OP_WRSR) & prot_hit)
		& ((pend_reg != SFP_OP_PROG) | (mask_reg != '0));
	assign start = launch_ok;

	// Instruction, address and data handling on the serial side.
	always_comb
	begin
		state_next = state_reg;
		pend_next = pend_reg;
		bit_cnt_next = bit_cnt_reg;
		rx_shift_next = rx_shift_reg;
		addr_cnt_next = addr_cnt_reg;
		addr_in_next = addr_in_reg;
		addr_next = addr_reg;
		tx_shift_next = tx_shift_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_on_next = tx_on_reg;
		wel_next = wel_reg;
		stat_new_next = stat_new_reg;
		mask_next = mask_reg;
		buf_we = 1'b0;
		if (cs_rise | ~selected_reg)
		begin
			state_next = SFP_S_CMD;
			pend_next = SFP_OP_NONE;
			bit_cnt_next = 3'h0;
			addr_cnt_next = 2'h0;
			tx_cnt_next = 3'h0;
			tx_on_next = 1'b0;
			if (launch_ok)
			begin
				wel_next = 1'b0;
			end
		end
		else if (rx_en)
		begin
			bit_cnt_next = bit_cnt_reg + 3'h1;
			rx_shift_next = rx_byte;
			if (bit_cnt_reg == 3'h7)
			begin
				case (state_reg)
					SFP_S_CMD:
					begin
						state_next = SFP_S_SKIP;
						if (busy & (rx_byte != `SFP_CMD_RDSR))
						begin
							state_next = SFP_S_SKIP;
						end
						else if (rx_byte == `SFP_CMD_WREN)
						begin
							wel_next = 1'b1;
						end
						else if (rx_byte == `SFP_CMD_WRDI)
						begin
							wel_next = 1'b0;
						end
						else if (rx_byte == `SFP_CMD_RDSR)
						begin
							state_next = SFP_S_STAT_OUT;
						end
						else if (rx_byte == `SFP_CMD_READ)
						begin
							pend_next = SFP_OP_READ;
							state_next = SFP_S_ADDR;
						end
						else if (wel_reg & (rx_byte == `SFP_CMD_PROG))
						begin
							pend_next = SFP_OP_PROG;
							state_next = SFP_S_ADDR;
						end
						else if (wel_reg & (rx_byte == `SFP_CMD_SECT))
						begin
							pend_next = SFP_OP_SECT;
							state_next = SFP_S_ADDR;
						end
						else if (wel_reg & (rx_byte == `SFP_CMD_BLK))
						begin
							pend_next = SFP_OP_BLK;
							state_next = SFP_S_ADDR;
						end
						else if (wel_reg & (rx_byte == `SFP_CMD_CHIP))
						begin
							pend_next = SFP_OP_CHIP;
						end
						else if (wel_reg & ~wrsr_locked & (rx_byte == `SFP_CMD_WRSR))
						begin
							state_next = SFP_S_STAT_IN;
						end
					end
					SFP_S_ADDR:
					begin
						addr_in_next = addr_full[15:0];
						addr_cnt_next = addr_cnt_reg + 2'h1;
						if (addr_cnt_reg == 2'h2)
						begin
							addr_next = addr_full[ADDR_W-1:0];
							if (pend_reg == SFP_OP_READ)
							begin
								state_next = SFP_S_READ;
							end
							else if (pend_reg == SFP_OP_PROG)
							begin
								state_next = SFP_S_PROG;
								mask_next = '0;
							end
							else
							begin
								state_next = SFP_S_SKIP;
							end
						end
					end
					SFP_S_STAT_IN:
					begin
						stat_new_next = rx_byte;
						pend_next = SFP_OP_WRSR;
						state_next = SFP_S_SKIP;
					end
					SFP_S_PROG:
					begin
						buf_we = 1'b1;
						mask_next[addr_reg[7:0]] = 1'b1;
						addr_next[7:0] = addr_reg[7:0] + 8'h01;
					end
					default:
					begin
						state_next = state_reg;
					end
				endcase
			end
		end
		else if (tx_en & ((state_reg == SFP_S_READ) | (state_reg == SFP_S_STAT_OUT)))
		begin
			tx_cnt_next = tx_cnt_reg + 3'h1;
			tx_on_next = 1'b1;
			if (tx_cnt_reg == 3'h0)
			begin
				tx_shift_next = (state_reg == SFP_S_READ) ? mem_rdata : status_w;
				if (state_reg == SFP_S_READ)
				begin
					addr_next = addr_reg + 1'b1;
				end
			end
			else
			begin
				tx_shift_next = {tx_shift_reg[6:0], 1'b0};
			end
		end
	end

	assign oe_n_next = ~(selected_reg & ~cs_n_s & ~pause_next & tx_on_next);

	// Program, erase and status write engine; it runs on regardless of the select pin.
	always_comb
	begin
		eng_next = eng_reg;
		op_next = op_reg;
		eng_addr_next = eng_addr_reg;
		eng_last_next = eng_last_reg;
		wait_cnt_next = wait_cnt_reg;
		bp_next = bp_reg;
		srp_next = srp_reg;
		mem_we = 1'b0;
		mem_wdata = 8'hFF;
		case (eng_reg)
			SFP_E_IDLE:
			begin
				if (start)
				begin
					op_next = pend_reg;
					wait_cnt_next = 16'h0000;
					eng_addr_next = '0;
					eng_last_next = '1;
					if (pend_reg == SFP_OP_PROG)
					begin
						eng_addr_next = {addr_reg[ADDR_W-1:`SFP_PAGE_W], 8'h00};
						eng_last_next = {addr_reg[ADDR_W-1:`SFP_PAGE_W], 8'hFF};
						eng_next = SFP_E_FETCH;
					end
					else if (pend_reg == SFP_OP_SECT)
					begin
						eng_addr_next = {addr_reg[ADDR_W-1:`SFP_SECT_LSB], 12'h000};
						eng_last_next = {addr_reg[ADDR_W-1:`SFP_SECT_LSB], 12'hFFF};
						eng_next = SFP_E_STORE;
					end
					else if (pend_reg == SFP_OP_BLK)
					begin
						eng_addr_next = {addr_reg[ADDR_W-1:`SFP_BLK_LSB], 16'h0000};
						eng_last_next = {addr_reg[ADDR_W-1:`SFP_BLK_LSB], 16'hFFFF};
						eng_next = SFP_E_STORE;
					end
					else if (pend_reg == SFP_OP_CHIP)
					begin
						eng_next = SFP_E_STORE;
					end
					else
					begin
						eng_next = SFP_E_WAIT;
					end
				end
			end
			SFP_E_FETCH:
			begin
				eng_next = SFP_E_STORE;
			end
			SFP_E_STORE:
			begin
				mem_we = 1'b1;
				if (op_reg == SFP_OP_PROG)
				begin
					mem_wdata = mem_rdata & (mask_reg[eng_addr_reg[7:0]] ? buf_rdata : 8'hFF);
				end
				if (eng_addr_reg == eng_last_reg)
				begin
					eng_next = SFP_E_IDLE;
				end
				else
				begin
					eng_addr_next = eng_addr_reg + 1'b1;
					eng_next = (op_reg == SFP_OP_PROG) ? SFP_E_FETCH : SFP_E_STORE;
				end
			end
			default:
			begin
				wait_cnt_next = wait_cnt_reg + 16'h0001;
				if (wait_cnt_reg == 16'(WRSR_CYCLES - 1))
				begin
					bp_next = stat_new_reg[`SFP_ST_BP_MSB:`SFP_ST_BP_LSB];
					srp_next = stat_new_reg[`SFP_ST_SRP];
					eng_next = SFP_E_IDLE;
				end
			end
		endcase
	end

	sfp_byte_mem #(.ADDR_W(ADDR_W), .DATA_W(8)) u_array (
		.clk_i(clk_i),
		.we_i(mem_we),
		.waddr_i(eng_addr_reg),
		.wdata_i(mem_wdata),
		.raddr_i(busy ? eng_addr_reg : addr_reg),
		.rdata_o(mem_rdata)
	);

	// Page buffer filled by the program instruction.
	sfp_byte_mem #(.ADDR_W(`SFP_PAGE_W), .DATA_W(8)) u_page_buf (
		.clk_i(clk_i),
		.we_i(buf_we),
		.waddr_i(addr_reg[7:0]),
		.wdata_i(rx_byte),
		.raddr_i(eng_addr_reg[7:0]),
		.rdata_o(buf_rdata)
	);

	// Pin edge history and select state.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			sclk_q_reg <= 1'b0;
			cs_n_q_reg <= 1'b0;
			selected_reg <= 1'b0;
			pause_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end
		else
		begin
			sclk_q_reg <= sclk_s;
			cs_n_q_reg <= cs_n_s;
			selected_reg <= selected_next;
			pause_reg <= pause_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// state held through pause
	// Serial side registers only move on live edges and on deselect, so a pause freezes them.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_reg <= SFP_S_CMD;
			pend_reg <= SFP_OP_NONE;
			bit_cnt_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			addr_cnt_reg <= 2'h0;
			addr_in_reg <= 16'h0000;
			addr_reg <= '0;
			tx_shift_reg <= 8'h00;
			tx_cnt_reg <= 3'h0;
			tx_on_reg <= 1'b0;
			wel_reg <= 1'b0;
			stat_new_reg <= `SFP_STATUS_RST;
			mask_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			bit_cnt_reg <= bit_cnt_next;
			rx_shift_reg <= rx_shift_next;
			addr_cnt_reg <= addr_cnt_next;
			addr_in_reg <= addr_in_next;
			addr_reg <= addr_next;
			tx_shift_reg <= tx_shift_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_on_reg <= tx_on_next;
			wel_reg <= wel_next;
			stat_new_reg <= stat_new_next;
			mask_reg <= mask_next;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			eng_reg <= SFP_E_IDLE;
			op_reg <= SFP_OP_NONE;
			eng_addr_reg <= '0;
			eng_last_reg <= '0;
			wait_cnt_reg <= 16'h0000;
			bp_reg <= 3'h0;
			srp_reg <= 1'b0;
		end
		else
		begin
			eng_reg <= eng_next;
			op_reg <= op_next;
			eng_addr_reg <= eng_addr_next;
			eng_last_reg <= eng_last_next;
			wait_cnt_reg <= wait_cnt_next;
			bp_reg <= bp_next;
			srp_reg <= srp_next;
		end
	end

	// Pin outputs; data and enable both come from flip-flops.
	assign serial_out_o = tx_shift_reg[7];
	assign serial_out_oe_n_o = oe_n_reg;
	// standby only when idle
	// The launch cycle is masked too, so standby never flickers high as an operation starts.
	assign standby_o = cs_n_s & ~busy & ~start;
endmodule : sfp_flash_front
`default_nettype wire

// [test/sfp_flash_front_asserts.sv]
// Pin-level checker for the serial flash front end, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_front_asserts (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Pins watched.
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic serial_in_i,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n_o,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	input wire logic standby_o
);
	logic sclk_q_reg;
	logic [3:0] fall_age_reg;
	logic [3:0] cs_lo_reg;
	// Cycles since the last serial clock fall and since selection, saturating.
	always_ff @(posedge clk_i)
	begin
		sclk_q_reg <= sclk_i;
		fall_age_reg <= (sclk_q_reg && !sclk_i) ? 4'h0 : fall_age_reg + {3'h0, fall_age_reg != 4'hF};
		cs_lo_reg <= cs_n_i ? 4'h0 : cs_lo_reg + {3'h0, cs_lo_reg != 4'hF};
		if (srst_i)
			fall_age_reg <= 4'hF;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	desel_float_a: assert property (cs_n_i [*6] |-> serial_out_oe_n_o)
		else $error("output driven while deselected");
	out_on_fall_a: assert property ((cs_lo_reg > 4'h6 && !serial_out_oe_n_o && !$past(serial_out_oe_n_o)
		&& $changed(serial_out_o)) |-> fall_age_reg <= 4'h6)
		else $error("output bit moved away from a clock fall");
	out_stable_a: assert property ((sclk_i && !cs_n_i && hold_n_i) [*6] |-> $stable(serial_out_o))
		else $error("output bit moved while clock high");
	oe_on_fall_a: assert property (($fell(serial_out_oe_n_o) && $past(hold_n_i, 8)) |->
		!cs_n_i && fall_age_reg <= 4'h7)
		else $error("output enabled without a clock fall");
	hold_float_a: assert property ((!hold_n_i && !sclk_i && !cs_n_i) [*8] |-> serial_out_oe_n_o)
		else $error("output driven while paused");
	pause_keep_a: assert property ((!hold_n_i && !cs_n_i && !sclk_i) [*8] ##1 (!hold_n_i && !cs_n_i) [*8]
		|-> $stable(serial_out_o))
		else $error("output state lost while paused");
	sel_active_a: assert property (!cs_n_i [*4] |-> !standby_o)
		else $error("standby while selected");
	standby_cause_a: assert property ($rose(standby_o) |-> $past(cs_n_i, 2))
		else $error("standby without deselect");
	reset_quiet_a: assert property ($fell(srst_i) |-> serial_out_oe_n_o && !serial_out_o)
		else $error("output active out of reset");
	// Main scenarios seen.
	cover property (!serial_out_oe_n_o && !cs_n_i);
	cover property ($fell(standby_o) ##0 cs_n_i);
	cover property ((!hold_n_i && !cs_n_i) [*8]);
endmodule : sfp_flash_front_asserts
bind sfp_flash_front sfp_flash_front_asserts u_chk (.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i),
	.cs_n_i(cs_n_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
	.serial_out_oe_n_o(serial_out_oe_n_o), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .standby_o(standby_o));
`default_nettype wire

// [test/sfp_spi_host.sv]
// Behavioural SPI host that drives the flash front end pins.
`timescale 1ns/1ps
`default_nettype none
module sfp_spi_host (
	// Link pins towards the device.
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	output logic hold_n_o,
	output logic wp_n_o,
	// Device output, its enable and a clock for the float pattern.
	input wire logic clk_i,
	input wire logic miso_i,
	input wire logic miso_oe_n_i
);
	realtime half = 62.5;
	logic mode3 = 1'b0;
	logic float_reg = 1'b0;
	logic miso_w;
	// A released output line shows a pattern that changes every cycle.
	always @(posedge clk_i) float_reg <= ~float_reg;
	assign miso_w = miso_oe_n_i ? float_reg : miso_i;
	// Idle pins.
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
		hold_n_o = 1'b1;
		wp_n_o = 1'b1;
	end
	// select fall starts every frame, clock idles at mode level.
	task automatic start;
		sclk_o = mode3;
		cs_n_o = 1'b0;
		#(half);
	endtask : start
	// Shifts n bits out MSB first, samples the reply on rising edges.
	task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk_o = 1'b0;
			mosi_o = tx[i];
			#(half);
			sclk_o = 1'b1;
			rx[i] = miso_w;
			#(half);
		end
	endtask : bits
	task automatic stop;
		sclk_o = mode3;
		#(half);
		cs_n_o = 1'b1;
		#(half * 4);
	endtask : stop
	// Pause entered with clock high, clock wiggles while paused, released with clock low.
	task automatic pause(output logic oe_seen);
		hold_n_o = 1'b0;
		#(half);
		sclk_o = 1'b0;
		repeat (3)
		begin
			#(half);
			sclk_o = 1'b1;
			#(half);
			sclk_o = 1'b0;
		end
		oe_seen = miso_oe_n_i;
		#(half);
		hold_n_o = 1'b1;
		#(half);
	endtask : pause
endmodule : sfp_spi_host
`default_nettype wire

// [test/sfp_flash_front_tb.sv]
// Self-checking testbench for the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
module sfp_flash_front_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	wire logic sclk, cs_n, mosi, hold_n, wp_n, so, so_oe_n, standby;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] s, r, r2;
	logic f;
	// System clock and run limit.
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			finish_test;
		end
	end
	sfp_flash_front dut (.clk_i(clk), .srst_i(srst), .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(mosi),
		.serial_out_o(so), .serial_out_oe_n_o(so_oe_n), .hold_n_i(hold_n), .wp_n_i(wp_n), .standby_o(standby));
	sfp_spi_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .hold_n_o(hold_n), .wp_n_o(wp_n),
		.clk_i(clk), .miso_i(so), .miso_oe_n_i(so_oe_n));
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t byte %h, expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t flag %b, expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic frame(input logic [7:0] op, input int nd, input logic [7:0] d);
		host.start;
		host.bits(op, 8, r);
		if (nd > 0)
			host.bits(d, 8, r);
		host.stop;
	endtask : frame
	task automatic rdsr(output logic [7:0] st);
		host.start;
		host.bits(`SFP_CMD_RDSR, 8, st);
		host.bits(8'h00, 8, st);
		host.stop;
	endtask : rdsr
	task automatic wait_idle(output logic [7:0] st);
		rdsr(st);
		for (int i = 0; i < 60 && st[0] !== 1'b0; i++)
			rdsr(st);
		chk1(st[0], 1'b0);
	endtask : wait_idle
	task automatic hdr(input logic [7:0] op, input logic [23:0] a);
		host.start;
		host.bits(op, 8, r);
		host.bits(a[23:16], 8, r);
		host.bits(a[15:8], 8, r);
		host.bits(a[7:0], 8, r);
	endtask : hdr
	task automatic rd1(input logic [23:0] a, output logic [7:0] d);
		hdr(`SFP_CMD_READ, a);
		host.bits(8'h00, 8, d);
		host.stop;
	endtask : rd1
	task automatic t_reset;
		chk1(standby, 1'b1);
		rdsr(s);
		chk8(s, `SFP_STATUS_RST);
	endtask : t_reset
	task automatic t_erase;
		frame(`SFP_CMD_WREN, 0, 8'h00);
		rdsr(s);
		chk8(s, 8'h02);
		hdr(`SFP_CMD_SECT, 24'h001800);
		host.stop;
		chk1(standby, 1'b0);
		rdsr(s);
		chk1(s[0], 1'b1);
		wait_idle(s);
		hdr(`SFP_CMD_READ, 24'hFC1FFE);
		host.bits(8'h00, 8, r);
		host.bits(8'h00, 8, r2);
		host.stop;
		chk8(r, 8'hFF);
		chk8(r2, 8'hFF);
	endtask : t_erase
	task automatic t_prog;
		frame(`SFP_CMD_WREN, 0, 8'h00);
		hdr(`SFP_CMD_PROG, 24'h0010FF);
		host.bits(8'hA5, 8, r);
		host.bits(8'h3C, 8, r);
		host.stop;
		wait_idle(s);
		chk8(s, 8'h00);
		rd1(24'h001000, r);
		chk8(r, 8'h3C);
		frame(`SFP_CMD_WREN, 0, 8'h00);
		frame(`SFP_CMD_PROG, 0, 8'h00);
		hdr(`SFP_CMD_PROG, 24'h001000);
		host.bits(8'h0F, 8, r);
		host.stop;
		wait_idle(s);
		rd1(24'h001000, r);
		chk8(r, 8'h0C);
	endtask : t_prog
	task automatic t_abort;
		host.start;
		host.bits(`SFP_CMD_READ, 8, r);
		host.bits(8'h00, 5, r);
		host.stop;
		rdsr(s);
		chk8(s, 8'h00);
	endtask : t_abort
	task automatic t_hold;
		hdr(`SFP_CMD_READ, 24'h0010FE);
		host.bits(8'h00, 8, r);
		chk8(r, 8'hFF);
		host.bits(8'h00, 4, r);
		host.pause(f);
		chk1(f, 1'b1);
		host.bits(8'h00, 4, r2);
		host.stop;
		chk8({r[3:0], r2[3:0]}, 8'hA5);
	endtask : t_hold
	task automatic t_mode3;
		host.mode3 = 1'b1;
		rd1(24'h0010FF, r);
		chk8(r, 8'hA5);
		rdsr(s);
		chk8(s, 8'h00);
		host.mode3 = 1'b0;
	endtask : t_mode3
	task automatic t_wrsr;
		frame(`SFP_CMD_WREN, 0, 8'h00);
		frame(`SFP_CMD_WRSR, 1, 8'h80);
		wait_idle(s);
		chk8(s, 8'h80);
		host.wp_n_o = 1'b0;
		frame(`SFP_CMD_WREN, 0, 8'h00);
		frame(`SFP_CMD_WRSR, 1, 8'h00);
		wait_idle(s);
		chk8(s & 8'hFD, 8'h80);
		host.wp_n_o = 1'b1;
		frame(`SFP_CMD_WREN, 0, 8'h00);
		frame(`SFP_CMD_WRSR, 1, 8'h00);
		wait_idle(s);
		chk8(s, 8'h00);
	endtask : t_wrsr
	// Block protection refuses chip and block erase over the guarded top sectors; disable clears the latch.
	task automatic t_protect;
		frame(`SFP_CMD_WREN, 0, 8'h00);
		frame(`SFP_CMD_WRSR, 1, 8'h04);
		wait_idle(s);
		chk8(s, 8'h04);
		frame(`SFP_CMD_WREN, 0, 8'h00);
		frame(`SFP_CMD_CHIP, 0, 8'h00);
		rdsr(s);
		chk8(s, 8'h06);
		hdr(`SFP_CMD_BLK, 24'h030000);
		host.stop;
		rdsr(s);
		chk8(s, 8'h06);
		frame(`SFP_CMD_WRDI, 0, 8'h00);
		rdsr(s);
		chk8(s, 8'h04);
		frame(`SFP_CMD_WREN, 0, 8'h00);
		frame(`SFP_CMD_WRSR, 1, 8'h00);
		wait_idle(s);
		chk8(s, 8'h00);
	endtask : t_protect
	task automatic finish_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// Reset, then the scenarios in order.
	initial
	begin
		repeat (10) @(negedge clk);
		srst = 1'b0;
		repeat (8) @(negedge clk);
		#0.25;
		t_reset;
		t_erase;
		t_prog;
		t_abort;
		t_hold;
		t_mode3;
		t_wrsr;
		t_protect;
		finish_test;
	end
endmodule : sfp_flash_front_tb
`default_nettype wire
